// >>> design/lfd_pkg.sv
// Package for the LED driver fault supervisor: timing, codes, carried types.
// Assumes a 10 MHz core clock; all cycle counts derive from the period below.
package lfd_pkg;
   // Clock period in ns
   localparam int CLK_NS = 100;
   // Gate held at one level longer than this is a stall, in ns
   localparam int STALL_NS = 100000;
   // Start-up diagnostic window, in ns
   localparam int STARTUP_NS = 100000;
   // Dimming low time before standby, in ns
   localparam int STBY_NS = 15000000;
   // Clamp-held dimming low time before shutdown, in ns
   localparam int SHUT_NS = 20000000;
   // Least times round up to whole cycles
   localparam int STALL_CYC = (STALL_NS + CLK_NS - 1) / CLK_NS;
   localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STBY_CYC = (STBY_NS + CLK_NS - 1) / CLK_NS;
   localparam int SHUT_CYC = (SHUT_NS + CLK_NS - 1) / CLK_NS;
   // Counter widths
   localparam int STALL_W = 10;
   localparam int START_W = 10;
   localparam int DIM_W = 18;

   // Condition inputs from the analog monitors, all asynchronous
   typedef struct packed {
      logic aux_uv; // Aux supply below threshold
      logic main_uv; // Main supply below threshold
      logic reg_loss; // Loop shaping node out of range
      logic temp_warn; // Die above warning level
      logic temp_shut; // Die above shutdown level
      logic sense_oc; // Sense voltage above limit
      logic gate_cmd; // Hysteretic comparator gate request
      logic dim; // Dimming input, high enables switching
   } lfd_cond_t;

   // Power mode, Gray along start, run, standby, shutdown
   typedef enum logic [1:0] {
      MODE_START = 2'h0,
      MODE_RUN = 2'h1,
      MODE_STBY = 2'h3,
      MODE_SHUT = 2'h2
   } lfd_mode_t;

   // Severity code, higher wins
   typedef enum logic [2:0] {
      SEV_NONE = 3'h0,
      SEV_AUX = 3'h1,
      SEV_REG = 3'h2,
      SEV_TEMP = 3'h3,
      SEV_OC = 3'h4
   } lfd_sev_t;

   // Fault level converter codes
   typedef enum logic [2:0] {
      LVL_4V5 = 3'h0,
      LVL_3V6 = 3'h1,
      LVL_1V8 = 3'h2,
      LVL_0V9 = 3'h3,
      LVL_GND = 3'h4
   } lfd_level_t;

   // Whole supervisor state
   typedef struct packed {
      lfd_mode_t mode; // Power mode
      logic [START_W-1:0] start_cnt; // Start-up window count
      logic [DIM_W-1:0] dim_cnt; // Dimming low count
      logic [STALL_W-1:0] stall_cnt; // Gate unchanged count
      logic stalled; // Stall detected
      logic tsd; // Thermal shutdown latched
      logic gate; // Output switch drive
      lfd_sev_t sev; // Active severity
      lfd_level_t level; // Fault level code
      logic fault_oe; // Fault indicator pulled low
      logic fault_val; // Open-drain output value
   } lfd_state_t;

   // Reset state: start-up mode, everything idle
   localparam lfd_state_t ST_RESET = lfd_state_t'('0);
endpackage : lfd_pkg

// >>> design/lfd_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs may change at any time relative to the clock.
`timescale 1ns/100ps
`default_nettype none
module lfd_sync #(
   parameter int W = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] in_i,
   output logic [W-1:0] out_o
);
   // Both stages of the chain
   typedef struct packed {
      logic [W-1:0] meta; // First stage, read only by second
      logic [W-1:0] sync; // Second stage, safe to use
   } lfd_sync_st_t;

   lfd_sync_st_t st;
   lfd_sync_st_t next_st;

   // Shift the chain
   always_comb begin
      next_st.meta = in_i;
      next_st.sync = st.meta;
   end

   // Register the chain
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign out_o = st.sync;
endmodule // lfd_sync
`default_nettype wire

// >>> design/lfd_supervisor.sv
// Fault and warning supervisor of a hysteretic LED driver controller.
// Assumes condition inputs straight from analog comparators, the dimming
// pin and the gate request; the fault indicator pin is open drain.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Above 125C warn, keep switching
// - Above 150C switch drive off
// - Resume only below 125C again
// - Fault indicator low on any condition
// - Level high normally, lower per condition
// - Aux undervoltage is severity 1, level high
// - Main UV, regulation, stall: severity 2
// - Gate unchanged over 100us is stall
// - Over 125C is severity 3
// - Sense over-current is severity 4
// - Highest severity picks the level
// - Start-up at power-on and leaving standby
// - Start-up transients may be reported
// - Dimming low keeps switch off
// - Dimming low over 20ms means shutdown
// - Standby drives level to ground
module lfd_supervisor import lfd_pkg::*; #(
   parameter int STBY_CYCLES = STBY_CYC, // Dimming low cycles to standby
   parameter int SHUT_CYCLES = SHUT_CYC // Dimming low cycles to shutdown
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire lfd_cond_t cond_i, // Asynchronous monitor levels
   output logic gate_o, // Output switch drive
   output logic fault_ind_o, // Open-drain value, always low
   output logic fault_ind_oe_o, // High while pulling indicator low
   output lfd_level_t level_o, // Fault level converter code
   output lfd_sev_t sev_o, // Active severity code
   output logic startup_o, // Start-up window in progress
   output logic standby_o, // Standby mode
   output logic shutdown_o, // Latched shutdown
   output logic tsd_o // Thermal shutdown active
);
   lfd_cond_t cs; // Synchronised conditions
   lfd_state_t st; // Registered state
   lfd_state_t next_st; // Next state
   logic en; // Switching allowed

   // Every monitor level crosses two flops first
   lfd_sync #(
      .W($bits(lfd_cond_t))
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_i(cond_i),
      .out_o(cs)
   );

   // Next-state logic
   always_comb begin
      next_st = st;
      // Dimming low timer, saturating at the shutdown count
      if (cs.dim) begin
         next_st.dim_cnt = '0;
      end else if (st.dim_cnt != DIM_W'(SHUT_CYCLES)) begin
         next_st.dim_cnt = st.dim_cnt + DIM_W'(1);
      end
      // Thermal latch with hysteresis
      if (cs.temp_shut) begin
         next_st.tsd = 1'b1;
      end else if (!cs.temp_warn) begin
         next_st.tsd = 1'b0;
      end
      // Power mode sequencing
      unique case (st.mode)
         MODE_START: begin
            // Start-up window runs its full length
            next_st.start_cnt = st.start_cnt + START_W'(1);
            if (st.start_cnt == START_W'(STARTUP_CYC - 1)) begin
               next_st.mode = MODE_RUN;
            end
         end
         MODE_RUN: begin
            next_st.start_cnt = '0;
         end
         MODE_STBY: begin
            // Dimming released: restart the sequence
            if (cs.dim) begin
               next_st.mode = MODE_START;
               next_st.start_cnt = '0;
            end
         end
         MODE_SHUT: begin
            next_st.start_cnt = '0;
         end
      endcase
      // Long dimming low overrides, shutdown held until reset
      if (st.mode != MODE_SHUT) begin
         if (next_st.dim_cnt == DIM_W'(SHUT_CYCLES)) begin
            next_st.mode = MODE_SHUT;
         end else if (next_st.dim_cnt == DIM_W'(STBY_CYCLES)) begin
            next_st.mode = MODE_STBY;
         end
      end
      // Gate drive gated by mode, dimming and thermal latch
      en = (next_st.mode == MODE_START || next_st.mode == MODE_RUN)
         && cs.dim && !next_st.tsd;
      next_st.gate = en && cs.gate_cmd;
      // Stall timer: gate unchanged while switching is allowed
      if (!en || next_st.gate != st.gate) begin
         next_st.stall_cnt = '0;
      end else if (st.stall_cnt != STALL_W'(STALL_CYC)) begin
         next_st.stall_cnt = st.stall_cnt + STALL_W'(1);
      end
      next_st.stalled = next_st.stall_cnt == STALL_W'(STALL_CYC);
      // Priority encode the severity
      if (cs.sense_oc) begin
         next_st.sev = SEV_OC;
      end else if (cs.temp_warn || cs.temp_shut) begin
         next_st.sev = SEV_TEMP;
      end else if (cs.main_uv || cs.reg_loss || next_st.stalled) begin
         next_st.sev = SEV_REG;
      end else if (cs.aux_uv) begin
         next_st.sev = SEV_AUX;
      end else begin
         next_st.sev = SEV_NONE;
      end
      // Level code from severity, ground when powered down
      if (next_st.mode == MODE_STBY || next_st.mode == MODE_SHUT) begin
         next_st.level = LVL_GND;
      end else begin
         unique case (next_st.sev)
            SEV_OC: next_st.level = LVL_0V9;
            SEV_TEMP: next_st.level = LVL_1V8;
            SEV_REG: next_st.level = LVL_3V6;
            default: next_st.level = LVL_4V5;
         endcase
      end
      // Indicator pulled low on any condition
      next_st.fault_oe = next_st.sev != SEV_NONE;
      next_st.fault_val = 1'b0;
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign gate_o = st.gate;
   assign fault_ind_o = st.fault_val;
   assign fault_ind_oe_o = st.fault_oe;
   assign level_o = st.level;
   assign sev_o = st.sev;
   assign startup_o = st.mode == MODE_START;
   assign standby_o = st.mode == MODE_STBY;
   assign shutdown_o = st.mode == MODE_SHUT;
   assign tsd_o = st.tsd;

   // Checks on the supervisor behaviour
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Leaving standby back into start-up
   sequence s_wake;
      (st.mode == MODE_STBY) ##1 (st.mode == MODE_START);
   endsequence

   // Over-temperature seen by the synchronised monitor
   sequence s_hot;
      cs.temp_shut ##1 1'b1;
   endsequence

   warn_keeps_gate_a: assert property (
      cs.temp_warn && !cs.temp_shut && !st.tsd && cs.dim && cs.gate_cmd
      && st.mode == MODE_RUN && !$past(cs.temp_shut) |=> st.gate)
      else $error("gate dropped on warning only");
   thermal_off_a: assert property (s_hot |-> st.tsd && !st.gate)
      else $error("gate still on above shutdown level");
   thermal_hyst_a: assert property (
      st.tsd && cs.temp_warn |=> st.tsd)
      else $error("thermal latch cleared above warning level");
   flag_sev_a: assert property ((st.sev != SEV_NONE) == st.fault_oe)
      else $error("indicator disagrees with severity");
   aux_level_a: assert property (
      st.sev == SEV_AUX && st.mode == MODE_RUN |-> st.level == LVL_4V5)
      else $error("aux undervoltage moved the level");
   oc_wins_a: assert property (
      cs.sense_oc && !$past(cs.sense_oc) ##0 cs.reg_loss
      |=> st.sev == SEV_OC && st.level != LVL_3V6)
      else $error("over-current did not take precedence");
   temp_level_a: assert property (
      st.sev == SEV_TEMP && st.mode == MODE_RUN |-> st.level == LVL_1V8)
      else $error("temperature level code wrong");
   stall_clear_a: assert property (
      st.gate != $past(st.gate) |-> !st.stalled && st.stall_cnt == '0)
      else $error("stall flag survived a gate toggle");
   dim_gate_a: assert property (!cs.dim ##1 !cs.dim |-> !st.gate [*2])
      else $error("switch driven while dimming low");
   standby_gnd_a: assert property (
      st.mode == MODE_STBY |-> st.level == LVL_GND && st.fault_oe == (st.sev != SEV_NONE))
      else $error("standby level not ground");
   wake_window_a: assert property (
      s_wake |-> ##[1:1000] (st.mode != MODE_START))
      else $error("start-up window overran");
   shut_hold_a: assert property (st.mode == MODE_SHUT |=> st.mode == MODE_SHUT)
      else $error("shutdown left without reset");
endmodule // lfd_supervisor
`default_nettype wire

// >>> verification/lfd_host.sv
// Host-side model: reads the open-drain indicator, drives the clamp.
// Assumes the indicator wire has a pull-up and the clamp ANDs onto dim.
`timescale 1ns/100ps
`default_nettype none
module lfd_host (
   input wire logic ref_clk_i,
   input wire logic fault_ind_i, // Open-drain value from the block
   input wire logic fault_ind_oe_i, // Block pulls the wire low
   input wire logic startup_i, // Start-up window flag
   input wire logic clamp_req_i, // Over-voltage present at the anode
   output logic flag_n_o, // Resolved indicator wire level
   output logic clamp_o, // High pulls dimming low
   output logic fault_seen_o // Fault as seen by the host
);
   // Pull-up wins while the block lets go
   assign flag_n_o = fault_ind_oe_i ? fault_ind_i : 1'b1;
   // Clamp holds dimming low while the anode is high
   assign clamp_o = clamp_req_i;
   // Diagnostics ignored during the start-up window
   always_ff @(posedge ref_clk_i) begin
      fault_seen_o <= !startup_i && !flag_n_o;
   end
endmodule // lfd_host
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the fault supervisor with a host model.
// Assumes short standby/shutdown counts set at the instance.
`timescale 1ns/100ps
`default_nettype none
module tb import lfd_pkg::*;;
   logic ref_clk_i, rst_n_i, tog, tgl, clamp_req, flag_n, clamp, seen;
   logic gate_o, fault_ind_o, fault_ind_oe_o, startup_o, standby_o, shutdown_o, tsd_o;
   lfd_cond_t cond, dut_cond; // Bench levels, levels after clamp
   lfd_level_t level_o;
   lfd_sev_t sev_o;
   logic [7:0] diag; // Gate, indicator, severity, level
   logic [3:0] mode; // Start-up, standby, shutdown, thermal
   int error_cnt = 0, num_checks = 0, cyc = 0;
   assign dut_cond = {cond[7:2], tog ? tgl : cond.gate_cmd, cond.dim & ~clamp};
   assign diag = {gate_o, fault_ind_oe_o, sev_o, level_o};
   assign mode = {startup_o, standby_o, shutdown_o, tsd_o};
   lfd_supervisor #(.STBY_CYCLES(200), .SHUT_CYCLES(300)) DUT (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .cond_i(dut_cond), .gate_o(gate_o), .fault_ind_o(fault_ind_o),
      .fault_ind_oe_o(fault_ind_oe_o), .level_o(level_o), .sev_o(sev_o),
      .startup_o(startup_o), .standby_o(standby_o), .shutdown_o(shutdown_o), .tsd_o(tsd_o));
   lfd_host u_host (.ref_clk_i(ref_clk_i), .fault_ind_i(fault_ind_o),
      .fault_ind_oe_i(fault_ind_oe_o), .startup_i(startup_o), .clamp_req_i(clamp_req),
      .flag_n_o(flag_n), .clamp_o(clamp), .fault_seen_o(seen));
   // Clock, 100 ns period
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   // Gate request toggler keeps the stall timer quiet; hang guard
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (tog && cyc[5:0] == 6'h0) tgl <= ~tgl;
      if (cyc == 8000) begin
         error_cnt = error_cnt + 1;
         conclude();
      end
   end
   // Move to 10 ns after the n-th rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #10;
   endtask
   // Compare and count
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Verdict and end of run
   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Start-up window with an over-current transient
   task automatic t_start();
      chk({4'h0, mode}, 8'h08);
      cond.sense_oc = 1'b1;
      tick(4);
      chk({4'h0, mode}, 8'h08);
      chk({1'b0, diag[6:0]}, {2'b01, SEV_OC, LVL_0V9});
      chk({7'h0, seen}, 8'h00);
      cond.sense_oc = 1'b0;
      tick(1000);
      chk({4'h0, mode}, 8'h00);
   endtask
   // Each condition except temp_shut alone, then stacked ones
   task automatic t_sev();
      int idx [5] = '{7, 6, 5, 4, 2};
      logic [2:0] sv [5] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
      logic [2:0] lv [5] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3};
      for (int i = 0; i < 5; i++) begin
         cond[idx[i]] = 1'b1;
         tick(4);
         chk({1'b0, diag[6:0]}, {2'b01, sv[i], lv[i]});
         chk({6'h0, flag_n, seen}, 8'h01);
         cond[idx[i]] = 1'b0;
         tick(4);
         chk({1'b0, diag[6:0]}, 8'h00);
         chk({7'h0, flag_n}, 8'h01);
      end
      {cond.aux_uv, cond.main_uv, cond.reg_loss, cond.temp_warn, cond.sense_oc} = 5'h1f;
      tick(4);
      chk({1'b0, diag[6:0]}, {2'b01, SEV_OC, LVL_0V9});
      cond.sense_oc = 1'b0;
      tick(4);
      chk({1'b0, diag[6:0]}, {2'b01, SEV_TEMP, LVL_1V8});
      {cond.aux_uv, cond.main_uv, cond.reg_loss, cond.temp_warn} = 4'h0;
      tick(4);
   endtask
   // Warning, shutdown and hysteresis
   task automatic t_therm();
      tog = 1'b0;
      cond.gate_cmd = 1'b1;
      cond.temp_warn = 1'b1;
      tick(4);
      chk(diag, {2'b11, SEV_TEMP, LVL_1V8});
      cond.temp_shut = 1'b1;
      tick(4);
      chk(diag, {2'b01, SEV_TEMP, LVL_1V8});
      chk({4'h0, mode}, 8'h01);
      cond.temp_shut = 1'b0;
      tick(4);
      chk(diag, {2'b01, SEV_TEMP, LVL_1V8});
      cond.temp_warn = 1'b0;
      tick(4);
      chk(diag, 8'h80);
      chk({4'h0, mode}, 8'h00);
   endtask
   // Gate held steady, then released
   task automatic t_stall();
      tick(900);
      chk(diag, 8'h80);
      tick(200);
      chk(diag, {2'b11, SEV_REG, LVL_3V6});
      cond.gate_cmd = 1'b0;
      tick(5);
      chk(diag, 8'h00);
   endtask
   // Dimming gate, standby and wake
   task automatic t_dim();
      cond.gate_cmd = 1'b1;
      tick(4);
      cond.dim = 1'b0;
      tick(4);
      chk(diag, 8'h00);
      tick(40);
      cond.dim = 1'b1;
      tick(4);
      chk(diag, 8'h80);
      cond.dim = 1'b0;
      tick(250);
      chk({4'h0, mode}, 8'h04);
      chk(diag, {2'b00, SEV_NONE, LVL_GND});
      chk({7'h0, flag_n}, 8'h01);
      tog = 1'b1;
      cond.dim = 1'b1;
      tick(5);
      chk({4'h0, mode}, 8'h08);
      tick(1000);
      chk({4'h0, mode}, 8'h00);
   endtask
   // Clamp holds dimming low past the shutdown count
   task automatic t_clamp();
      clamp_req = 1'b1;
      tick(350);
      chk({4'h0, mode}, 8'h02);
      chk({5'h0, diag[2:0]}, {5'h0, LVL_GND});
      clamp_req = 1'b0;
      tick(10);
      chk({3'h0, gate_o, mode}, 8'h02);
   endtask
   // Main sequence
   initial begin
      cond = '0;
      tgl = 1'b0;
      cond.dim = 1'b1;
      tog = 1'b1;
      clamp_req = 1'b0;
      rst_n_i = 1'b0;
      tick(20);
      chk({1'b0, diag[6:0]}, 8'h00);
      rst_n_i = 1'b1;
      tick(1);
      t_start();
      t_sev();
      t_therm();
      t_stall();
      t_dim();
      t_clamp();
      conclude();
   end
endmodule // tb
`default_nettype wire
